// >>> logic/irq_ctrl_defs.svh
// Offsets, field layouts, masks and reset values of the interrupt flag and enable block
// Operation
// - Stack error trap sets bit 2
// - Oscillator failure trap sets bit 1
// - Bit 15 selects the alternate vector table
// - Bit 14 reads timed disable status
// - Polarity bit 1 falling, 0 rising edge
// - Request flags show occurred requests, read/write
// - Enable bits gate requests, read/write
// - Unimplemented bits read zero, ignore writes
// - Group 0 flag positions 13..5, 3..0
// - Group 1 flag positions 13,7,6,4,3,1,0
// - Group 3 flags at 15, 10, 9
// - Group 4 flags at 10, 9, 1
// - Group 0 enables mirror group 0 flags
// - Sources set flags, software clears them
// - Priority 000 disables, 7 is highest
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_TRAP_CTRL     6'h00
`define OFS_VSEL_EDGE     6'h04
`define OFS_FLAGS0        6'h08
`define OFS_FLAGS1        6'h0c
`define OFS_FLAGS3        6'h10
`define OFS_FLAGS4        6'h14
`define OFS_ENABLES0      6'h18
`define OFS_PRIORITY0     6'h1c
`define OFS_EVT_STATUS    6'h20
`define OFS_EVT_CLEAR     6'h24
`define OFS_EVT_ENABLE    6'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_STACK_FAULT   1
`define BIT_CLOCK_FAIL    1
`define POS_STACK_FAULT   2
`define POS_CLOCK_FAIL    1
`define POS_ALT_TABLE     15
`define POS_TIMED_DIS     14
`define POS_EXT0_FLAG     0
`define POS_EXT1_FLAG     4
`define POS_EXT2_FLAG     13
`define EVT_STACK         0
`define EVT_CLOCK         1
`define EVT_EXT0          2
`define EVT_EXT1          3
`define EVT_EXT2          4

// ----------------------------------------
// Implemented bit masks
// ----------------------------------------
`define MASK_TRAP         16'h0006
`define MASK_VSEL_WR      16'h8007
`define MASK_FLAGS0       16'h3fef
`define MASK_FLAGS1       16'h20db
`define MASK_FLAGS3       16'h8600
`define MASK_FLAGS4       16'h0602
`define MASK_PRIORITY0    16'h7777
`define MASK_EVT          16'h001f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_REG16         16'h0000
`define RST_LEVEL         3'h0

`endif

// >>> logic/irq_ctrl_pkg.sv
// Types shared by the interrupt flag and enable block
package irq_ctrl_pkg;
  typedef logic [15:0] reg16_type;
  typedef logic [2:0]  level_type;
  typedef logic [1:0]  source_type;
endpackage : irq_ctrl_pkg

// >>> logic/interrupt_flag_enable_control.sv
// Interrupt request flags, enables, trap status and edge control with a Wishbone slave
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "irq_ctrl_defs.svh"

module interrupt_flag_enable_control #(
  parameter int EXT_PINS = 3
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [5:0]                adr_i,
  input  wire logic [31:0]               dat_i,
  input  wire logic [3:0]                sel_i,
  output      logic [31:0]               dat_o,
  output      logic                      ack_o,
  input  wire logic [15:0]               req_group0,
  input  wire logic [15:0]               req_group1,
  input  wire logic [15:0]               req_group3,
  input  wire logic [15:0]               req_group4,
  input  wire logic [EXT_PINS-1:0]       ext_int_pin,
  input  wire logic                      stack_error_trap,
  input  wire logic                      clock_failure_trap,
  input  wire logic                      timed_irq_disable_active,
  output      logic                      alternate_table_select,
  output      irq_ctrl_pkg::reg16_type   pending_group0,
  output      logic                      arb_valid,
  output      irq_ctrl_pkg::level_type   arb_level,
  output      irq_ctrl_pkg::source_type  arb_source,
  output      logic                      irq
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic irq_ctrl_pkg::reg16_type lane_merge(
    input irq_ctrl_pkg::reg16_type old_val,
    input irq_ctrl_pkg::reg16_type new_val,
    input logic [1:0]              lanes,
    input irq_ctrl_pkg::reg16_type impl
  );
    irq_ctrl_pkg::reg16_type m;
    m = {{8{lanes[1]}}, {8{lanes[0]}}} & impl;
    return (old_val & ~m) | (new_val & m);
  endfunction : lane_merge

  function automatic irq_ctrl_pkg::level_type prio_field(
    input irq_ctrl_pkg::reg16_type pr,
    input int                      idx
  );
    return pr[idx*4 +: 3];
  endfunction : prio_field

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  irq_ctrl_pkg::reg16_type trap_control_register;
  irq_ctrl_pkg::reg16_type vector_select_and_edge_control;
  irq_ctrl_pkg::reg16_type request_flags_group0;
  irq_ctrl_pkg::reg16_type request_flags_group1;
  irq_ctrl_pkg::reg16_type request_flags_group3;
  irq_ctrl_pkg::reg16_type request_flags_group4;
  irq_ctrl_pkg::reg16_type request_enables_group0;
  irq_ctrl_pkg::reg16_type priority_fields_group0;
  irq_ctrl_pkg::reg16_type event_status;
  irq_ctrl_pkg::reg16_type event_enable;

  irq_ctrl_pkg::reg16_type next_trap_control_register;
  irq_ctrl_pkg::reg16_type next_vector_select_and_edge_control;
  irq_ctrl_pkg::reg16_type next_request_flags_group0;
  irq_ctrl_pkg::reg16_type next_request_flags_group1;
  irq_ctrl_pkg::reg16_type next_request_flags_group3;
  irq_ctrl_pkg::reg16_type next_request_flags_group4;
  irq_ctrl_pkg::reg16_type next_request_enables_group0;
  irq_ctrl_pkg::reg16_type next_priority_fields_group0;
  irq_ctrl_pkg::reg16_type next_event_status;
  irq_ctrl_pkg::reg16_type next_event_enable;
  irq_ctrl_pkg::reg16_type next_pending_group0;
  logic                    next_arb_valid;
  irq_ctrl_pkg::level_type next_arb_level;
  irq_ctrl_pkg::source_type next_arb_source;
  logic                    next_irq;

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  logic        next_ack;
  logic [31:0] next_dat;
  logic        wr_commit;
  logic [1:0]  lanes;
  irq_ctrl_pkg::reg16_type wdata;
  irq_ctrl_pkg::reg16_type rdata;

  // ----------------------------------------
  // External pin synchronisers
  // ----------------------------------------
  logic [EXT_PINS-1:0] pin_meta;
  logic [EXT_PINS-1:0] pin_sync;
  logic [EXT_PINS-1:0] pin_last;
  logic [EXT_PINS-1:0] next_pin_last;
  logic [EXT_PINS-1:0] ext_edge;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= ext_int_pin;
      pin_sync <= pin_meta;
      pin_last <= next_pin_last;
    end
  end

  always_comb begin
    next_pin_last = pin_sync;
    for (int i = 0; i < EXT_PINS; i++) begin
      if (vector_select_and_edge_control[i]) begin
        ext_edge[i] = pin_last[i] & ~pin_sync[i];
      end else begin
        ext_edge[i] = ~pin_last[i] & pin_sync[i];
      end
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign lanes     = sel_i[1:0];
  assign wdata     = dat_i[15:0];
  assign wr_commit = cyc_i & stb_i & we_i & ack_o;

  always_comb begin
    unique case (adr_i)
      `OFS_TRAP_CTRL:  rdata = trap_control_register & `MASK_TRAP;
      `OFS_VSEL_EDGE:  rdata = (vector_select_and_edge_control & `MASK_VSEL_WR)
                               | (16'(timed_irq_disable_active) << `POS_TIMED_DIS);
      `OFS_FLAGS0:     rdata = request_flags_group0;
      `OFS_FLAGS1:     rdata = request_flags_group1;
      `OFS_FLAGS3:     rdata = request_flags_group3;
      `OFS_FLAGS4:     rdata = request_flags_group4;
      `OFS_ENABLES0:   rdata = request_enables_group0;
      `OFS_PRIORITY0:  rdata = priority_fields_group0;
      `OFS_EVT_STATUS: rdata = event_status;
      `OFS_EVT_ENABLE: rdata = event_enable;
      default:         rdata = `RST_REG16;
    endcase
    next_ack = cyc_i & stb_i & ~ack_o;
    next_dat = (cyc_i & stb_i & ~we_i & ~ack_o) ? {16'h0000, rdata} : 32'h0000_0000;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------
  // Flag, enable and control registers
  // ----------------------------------------
  always_comb begin
    irq_ctrl_pkg::reg16_type set0;
    irq_ctrl_pkg::reg16_type set1;
    irq_ctrl_pkg::reg16_type evt;
    irq_ctrl_pkg::reg16_type req0;
    irq_ctrl_pkg::level_type lvl;
    set0 = '0;
    set1 = '0;
    evt  = '0;
    req0 = '0;
    lvl  = '0;

    next_trap_control_register          = trap_control_register;
    next_vector_select_and_edge_control = vector_select_and_edge_control;
    next_request_flags_group0           = request_flags_group0;
    next_request_flags_group1           = request_flags_group1;
    next_request_flags_group3           = request_flags_group3;
    next_request_flags_group4           = request_flags_group4;
    next_request_enables_group0         = request_enables_group0;
    next_priority_fields_group0         = priority_fields_group0;
    next_event_status                   = event_status;
    next_event_enable                   = event_enable;

    // Software writes with byte lanes
    if (wr_commit) begin
      unique case (adr_i)
        `OFS_TRAP_CTRL:  next_trap_control_register =
                           lane_merge(trap_control_register, wdata, lanes, `MASK_TRAP);
        `OFS_VSEL_EDGE:  next_vector_select_and_edge_control =
                           lane_merge(vector_select_and_edge_control, wdata, lanes, `MASK_VSEL_WR);
        `OFS_FLAGS0:     next_request_flags_group0 =
                           lane_merge(request_flags_group0, wdata, lanes, `MASK_FLAGS0);
        `OFS_FLAGS1:     next_request_flags_group1 =
                           lane_merge(request_flags_group1, wdata, lanes, `MASK_FLAGS1);
        `OFS_FLAGS3:     next_request_flags_group3 =
                           lane_merge(request_flags_group3, wdata, lanes, `MASK_FLAGS3);
        `OFS_FLAGS4:     next_request_flags_group4 =
                           lane_merge(request_flags_group4, wdata, lanes, `MASK_FLAGS4);
        `OFS_ENABLES0:   next_request_enables_group0 =
                           lane_merge(request_enables_group0, wdata, lanes, `MASK_FLAGS0);
        `OFS_PRIORITY0:  next_priority_fields_group0 =
                           lane_merge(priority_fields_group0, wdata, lanes, `MASK_PRIORITY0);
        `OFS_EVT_CLEAR:  next_event_status =
                           event_status & ~(wdata & {{8{lanes[1]}}, {8{lanes[0]}}});
        `OFS_EVT_ENABLE: next_event_enable =
                           lane_merge(event_enable, wdata, lanes, `MASK_EVT);
        default: ;
      endcase
    end

    if (stack_error_trap) begin
      next_trap_control_register[`POS_STACK_FAULT] = 1'b1;
    end
    if (clock_failure_trap) begin
      next_trap_control_register[`POS_CLOCK_FAIL] = 1'b1;
    end

    set0 = req_group0;
    set0[`POS_EXT0_FLAG] = req_group0[`POS_EXT0_FLAG] | ext_edge[0];
    set1 = req_group1;
    set1[`POS_EXT1_FLAG] = req_group1[`POS_EXT1_FLAG] | ext_edge[1];
    set1[`POS_EXT2_FLAG] = req_group1[`POS_EXT2_FLAG] | ext_edge[2];

    next_request_flags_group0 = next_request_flags_group0 | (set0 & `MASK_FLAGS0);
    next_request_flags_group1 = next_request_flags_group1 | (set1 & `MASK_FLAGS1);
    next_request_flags_group3 = next_request_flags_group3 | (req_group3 & `MASK_FLAGS3);
    next_request_flags_group4 = next_request_flags_group4 | (req_group4 & `MASK_FLAGS4);

    // Sticky event status, set beats clear
    evt[`EVT_STACK] = stack_error_trap;
    evt[`EVT_CLOCK] = clock_failure_trap;
    evt[`EVT_EXT0]  = ext_edge[0];
    evt[`EVT_EXT1]  = ext_edge[1];
    evt[`EVT_EXT2]  = ext_edge[2];
    next_event_status = next_event_status | evt;
    next_irq = |(next_event_status & next_event_enable);

    next_pending_group0 = next_request_flags_group0 & next_request_enables_group0;

    next_arb_valid  = 1'b0;
    next_arb_level  = `RST_LEVEL;
    next_arb_source = '0;
    for (int i = 0; i < 4; i++) begin
      req0 = next_pending_group0;
      lvl  = prio_field(next_priority_fields_group0, i);
      if (req0[i] && lvl != `RST_LEVEL && lvl > next_arb_level) begin
        next_arb_valid  = 1'b1;
        next_arb_level  = lvl;
        next_arb_source = 2'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_control_register          <= `RST_REG16;
      vector_select_and_edge_control <= `RST_REG16;
      request_flags_group0           <= `RST_REG16;
      request_flags_group1           <= `RST_REG16;
      request_flags_group3           <= `RST_REG16;
      request_flags_group4           <= `RST_REG16;
      request_enables_group0         <= `RST_REG16;
      priority_fields_group0         <= `RST_REG16;
      event_status                   <= `RST_REG16;
      event_enable                   <= `RST_REG16;
      pending_group0                 <= `RST_REG16;
      arb_valid                      <= 1'b0;
      arb_level                      <= `RST_LEVEL;
      arb_source                     <= '0;
      irq                            <= 1'b0;
    end else begin
      trap_control_register          <= next_trap_control_register;
      vector_select_and_edge_control <= next_vector_select_and_edge_control;
      request_flags_group0           <= next_request_flags_group0;
      request_flags_group1           <= next_request_flags_group1;
      request_flags_group3           <= next_request_flags_group3;
      request_flags_group4           <= next_request_flags_group4;
      request_enables_group0         <= next_request_enables_group0;
      priority_fields_group0         <= next_priority_fields_group0;
      event_status                   <= next_event_status;
      event_enable                   <= next_event_enable;
      pending_group0                 <= next_pending_group0;
      arb_valid                      <= next_arb_valid;
      arb_level                      <= next_arb_level;
      arb_source                     <= next_arb_source;
      irq                            <= next_irq;
    end
  end

  assign alternate_table_select = vector_select_and_edge_control[`POS_ALT_TABLE];

endmodule : interrupt_flag_enable_control

// >>> sim/irq_sources.sv
// Model of the peripherals, pins and core that feed the block's request inputs
module irq_sources (
  input  wire logic        clk,
  output logic [15:0]      req_group0,
  output logic [15:0]      req_group1,
  output logic [15:0]      req_group3,
  output logic [15:0]      req_group4,
  output logic [2:0]       ext_int_pin,
  output logic             stack_error_trap,
  output logic             clock_failure_trap,
  output logic             timed_irq_disable_active
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req_group0, req_group1, req_group3, req_group4} = '0;
    {stack_error_trap, clock_failure_trap, timed_irq_disable_active} = 3'h0;
    ext_int_pin = 3'h0;
  end
  task automatic pulse(input int g, input logic [15:0] v);
    @(posedge clk);
    case (g)
      0: req_group0 <= v;
      1: req_group1 <= v;
      3: req_group3 <= v;
      4: req_group4 <= v;
      default: {stack_error_trap, clock_failure_trap} <= v[2:1];
    endcase
    @(posedge clk);
    {req_group0, req_group1, req_group3, req_group4, stack_error_trap, clock_failure_trap} <= '0;
  endtask : pulse
  task automatic set_pin(input int n, input logic v);
    @(posedge clk);
    ext_int_pin[n] <= v;
  endtask : set_pin
  task automatic set_dis(input logic v);
    @(posedge clk);
    timed_irq_disable_active <= v;
  endtask : set_dis
endmodule : irq_sources

// >>> sim/interrupt_flag_enable_control_props.sv
// Port checker for the interrupt flag and enable block
module irq_ctrl_checker #(
  parameter int EXT_PINS = 3
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     cyc_i,
  input wire logic                     stb_i,
  input wire logic                     we_i,
  input wire logic [5:0]               adr_i,
  input wire logic [31:0]              dat_o,
  input wire logic                     ack_o,
  input wire logic                     alternate_table_select,
  input wire irq_ctrl_pkg::reg16_type  pending_group0,
  input wire logic                     arb_valid,
  input wire irq_ctrl_pkg::level_type  arb_level,
  input wire irq_ctrl_pkg::source_type arb_source,
  input wire logic                     irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_irq_quiet; irq && !(cyc_i && stb_i && we_i); endsequence
  property p_ack_next; s_req |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  property p_dat_hi; ack_o |-> dat_o[31:16] == 16'h0; endproperty
  property p_alt_src;
    $changed(alternate_table_select) |-> $past(ack_o) && $past(we_i) && $past(adr_i) == 6'h04;
  endproperty
  property p_pend_map; (pending_group0 & 16'hc010) == 16'h0; endproperty
  property p_arb_lvl; arb_valid |-> arb_level != 3'h0; endproperty
  property p_arb_pend; arb_valid |-> pending_group0[arb_source]; endproperty
  property p_irq_hold; s_irq_quiet |=> irq; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
  a_alt_src: assert property (p_alt_src) else $error("table select moved");
  a_pend_map: assert property (p_pend_map) else $error("pending on empty bit");
  a_arb_lvl: assert property (p_arb_lvl) else $error("zero level valid");
  a_arb_pend: assert property (p_arb_pend) else $error("source not pending");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule : irq_ctrl_checker

bind interrupt_flag_enable_control irq_ctrl_checker #(.EXT_PINS(EXT_PINS)) i_irq_ctrl_checker (
  .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .alternate_table_select(alternate_table_select),
  .pending_group0(pending_group0), .arb_valid(arb_valid), .arb_level(arb_level),
  .arb_source(arb_source), .irq(irq));

// >>> sim/tb_interrupt_flag_enable_control.sv
// Testbench of the interrupt flag and enable block
module tb_interrupt_flag_enable_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [5:0] adr_i = 6'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [3:0] sel_i = 4'h0;
  logic [15:0] rg0, rg1, rg3, rg4, pend;
  logic [2:0] pins, al;
  logic [1:0] as;
  logic ack_o, st, cf, td, alt, av, irq;
  int error_cnt = 0;
  int checks_done = 0;
  logic [5:0] ofs [8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h28};
  logic [15:0] msk [8] = '{16'h8007, 16'h3fef, 16'h20db, 16'h8600, 16'h0602, 16'h3fef, 16'h7777, 16'h001f};
  always #2 clk = ~clk;
  irq_sources i_irq_sources (.clk(clk), .req_group0(rg0), .req_group1(rg1), .req_group3(rg3),
    .req_group4(rg4), .ext_int_pin(pins), .stack_error_trap(st), .clock_failure_trap(cf),
    .timed_irq_disable_active(td));
  interrupt_flag_enable_control #(.EXT_PINS(3)) i_interrupt_flag_enable_control (.clk(clk),
    .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .req_group0(rg0), .req_group1(rg1),
    .req_group3(rg3), .req_group4(rg4), .ext_int_pin(pins), .stack_error_trap(st),
    .clock_failure_trap(cf), .timed_irq_disable_active(td), .alternate_table_select(alt),
    .pending_group0(pend), .arb_valid(av), .arb_level(al), .arb_source(as), .irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, d};
    sel_i <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (ack_o !== 1'h1) begin
      chk("ack", 32'h1, {31'h0, ack_o});
      wrap_up();
    end else begin
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
    end
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, 4'h3, q);
  endtask : wr
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 16'h0, 4'h3, q);
    chk(n, e, q);
  endtask : rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rd("reset value", 6'(i * 4), 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rw();
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], 16'hffff);
      rd("masked readback", ofs[i], {16'h0, msk[i]});
    end
    chk("table select", 32'h1, {31'h0, alt});
    bus(1'h1, 6'h18, 16'h0, 4'h1, q);
    rd("lane write", 6'h18, 32'h3f00);
    wr(6'h20, 16'hffff);
    rd("status write", 6'h20, 32'h0);
    for (int i = 0; i < 8; i++) wr(ofs[i], 16'h0);
    rd("enables cleared", 6'h18, 32'h0);
    chk("table select", 32'h0, {31'h0, alt});
    $display("t_rw done");
  endtask : t_rw
  task automatic t_req();
    int g [4] = '{0, 1, 3, 4};
    for (int i = 0; i < 4; i++) begin
      i_irq_sources.pulse(g[i], 16'hffff);
      rd("flags set", ofs[i + 1], {16'h0, msk[i + 1]});
      wr(ofs[i + 1], 16'h0);
      rd("flags clear", ofs[i + 1], 32'h0);
    end
    $display("t_req done");
  endtask : t_req
  task automatic t_trap();
    i_irq_sources.pulse(5, 16'h0004);
    rd("stack fault", 6'h00, 32'h4);
    i_irq_sources.pulse(5, 16'h0002);
    rd("clock fail", 6'h00, 32'h6);
    rd("event status", 6'h20, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(6'h28, 16'h1);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(6'h24, 16'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd("status left", 6'h20, 32'h2);
    wr(6'h24, 16'h3);
    wr(6'h28, 16'h0);
    wr(6'h00, 16'h0);
    rd("trap cleared", 6'h00, 32'h0);
    $display("t_trap done");
  endtask : t_trap
  task automatic t_edge();
    logic [5:0] fo [3] = '{6'h08, 6'h0c, 6'h0c};
    logic [31:0] fb [3] = '{32'h1, 32'h10, 32'h2000};
    for (int n = 0; n < 3; n++) begin
      i_irq_sources.set_pin(n, 1'h1);
      repeat (6) @(posedge clk);
      rd("rising edge", fo[n], fb[n]);
      wr(fo[n], 16'h0);
      wr(6'h04, 16'(1 << n));
      i_irq_sources.set_pin(n, 1'h0);
      repeat (6) @(posedge clk);
      rd("falling edge", fo[n], fb[n]);
      wr(fo[n], 16'h0);
      i_irq_sources.set_pin(n, 1'h1);
      repeat (6) @(posedge clk);
      rd("wrong edge", fo[n], 32'h0);
      wr(6'h04, 16'h0);
    end
    wr(6'h24, 16'h1f);
    $display("t_edge done");
  endtask : t_edge
  task automatic t_dis();
    i_irq_sources.set_dis(1'h1);
    rd("timed disable", 6'h04, 32'h4000);
    i_irq_sources.set_dis(1'h0);
    rd("timed disable", 6'h04, 32'h0);
    $display("t_dis done");
  endtask : t_dis
  task automatic t_arb();
    wr(6'h18, 16'h0008);
    i_irq_sources.pulse(0, 16'h0009);
    repeat (2) @(posedge clk);
    chk("pending", 32'h8, {16'h0, pend});
    chk("arb off", 32'h0, {31'h0, av});
    wr(6'h1c, 16'h5000);
    repeat (2) @(posedge clk);
    chk("arb", 32'h1_5_3, {20'h0, 3'h0, av, 1'h0, al, 2'h0, as});
    wr(6'h18, 16'h0009);
    wr(6'h1c, 16'h5006);
    repeat (2) @(posedge clk);
    chk("arb highest", 32'h1_6_0, {20'h0, 3'h0, av, 1'h0, al, 2'h0, as});
    wr(6'h1c, 16'h5002);
    repeat (2) @(posedge clk);
    chk("arb highest", 32'h1_5_3, {20'h0, 3'h0, av, 1'h0, al, 2'h0, as});
    wr(6'h18, 16'h0);
    repeat (2) @(posedge clk);
    chk("disabled", 32'h0, {15'h0, av, pend});
    wr(6'h08, 16'h0);
    $display("t_arb done");
  endtask : t_arb
  task automatic t_rst();
    wr(6'h04, 16'h8000);
    wr(6'h18, 16'h3fef);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    chk("reset table select", 32'h0, {31'h0, alt});
    rd("reset enables", 6'h18, 32'h0);
    rd("reset priority", 6'h1c, 32'h0);
    rd("reset control", 6'h04, 32'h0);
    $display("t_rst done");
  endtask : t_rst
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_rw();
    t_req();
    t_trap();
    t_edge();
    t_dis();
    t_arb();
    t_rst();
    wrap_up();
  end
endmodule : tb_interrupt_flag_enable_control
